/* File: design/fbmc_core.v */
// Four-bit microcomputer core with program memory and decode arrays
// Operation
// [R01] Data memory holds 64 four-bit words in four files of 16.
// [R02] File select picks the file, word pointer picks word within it.
// [R03] File select changes only by constant load or complement.
// [R04] Word pointer: compare, load constant, increment, decrement, adder transfers.
// [R05] Memory write data comes from accumulator or an instruction constant.
// [R06] Memory word feeds adder; result loads pointer or accumulator same cycle.
// [R07] Any selected bit of addressed memory word can be set, cleared, tested.
// [R08] Program memory: 16 pages of 64 eight-bit words, page register selects.
// [R09] Start at fixed address; shift-register counter steps within page.
// [R10] Taken branch or call loads six-bit in-page address from instruction.
// [R11] One level of return address in a return register.
// [R12] Constant loads page buffer; copied to page only on taken transfer.
// [R13] In call mode page buffer keeps the return page.
// [R14] P and N adder operands selectable from listed sources.
// [R15] Subtraction uses inverted accumulator on N operand.
// [R16] Add results go to pointer or accumulator; compares touch only status.
// [R17] Status normally one; missing routed carry clears it one cycle.
// [R18] Logical compare with all bits equal clears status one cycle.
// [R19] Branch and call taken only when status is one.
// [R20] Inputs reach adder; tested nonzero into status or stored in accumulator.
// [R21] Each strobe output latch addressed by pointer, set or cleared.
// [R22] Output load copies accumulator and status latch into five-bit latch.
// [R23] Output latch bits drive 20 programmable terms onto eight outputs.
// [R24] Thirty programmable terms decode instruction into 16 micro-operations.
// [R25] External fixed-rate source starts only after strobe handshake output.
// [R26] Each instruction completes in one cycle of six oscillator pulses.
// [R27] Reset forces status one, clears strobe latches and output latch.
//
// Design decisions made here: the address map and strobed register access.
`timescale 1ns/10ps
`include "fbmc_defines.vh"

module fbmc_core (
  // Clock and reset
  input  wire        clock,
  input  wire        rst,
  // Register port
  input  wire [10:0] regAddr,
  input  wire [31:0] regWrData,
  input  wire        regWrite,
  input  wire        regRead,
  output reg  [31:0] regRdData,
  // Data inputs
  input  wire        input_bit_weight1,
  input  wire        input_bit_weight2,
  input  wire        input_bit_weight4,
  input  wire        input_bit_weight8,
  // Outputs
  output reg  [`FBMC_R_COUNT-1:0] strobeOut,
  output reg  [7:0]  decodedOut
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg  [7:0]  progMem [0:`FBMC_ROM_WORDS-1];
  reg  [3:0]  dataMem [0:`FBMC_RAM_WORDS-1];
  reg  [31:0] instrArray [0:`FBMC_IPLA_TERMS-1];
  reg  [17:0] outArray [0:`FBMC_OPLA_TERMS-1];

  reg         run;
  reg  [2:0]  phase;
  reg  [3:0]  page;
  reg  [3:0]  pageBuf;
  reg  [5:0]  pc;
  reg  [5:0]  retAddr;
  reg         callMode;
  reg  [1:0]  fileSel;
  reg  [3:0]  wordPtr;
  reg  [3:0]  acc;
  reg         status;
  reg         status_latch_bit;
  reg  [4:0]  outLatch;

  wire [3:0]  kIn = {input_bit_weight8, input_bit_weight4,
                     input_bit_weight2, input_bit_weight1};
  wire        step = run & (phase == `FBMC_OSC_PER_CYCLE - 3'h1);  // [R26]

  // ----------------------------------------------------------------
  // Fetch and fixed decode
  // ----------------------------------------------------------------
  wire [9:0]  fetchAddr = {page, pc};  // [R08]
  wire [7:0]  instr     = progMem[fetchAddr];
  wire [3:0]  konst     = instr[3:0];
  wire [5:0]  ramAddr   = {fileSel, wordPtr};  // [R01] [R02]
  wire [3:0]  memWord   = dataMem[ramAddr];
  wire [1:0]  bitSel    = instr[1:0];

  wire isBr    = (instr[7:6] == 2'b10);
  wire isCall  = (instr[7:6] == 2'b11);
  wire isLdp   = (instr[7:4] == `FBMC_GRP_LDP);
  wire isTcy   = (instr[7:4] == `FBMC_GRP_TCY);
  wire isYnec  = (instr[7:4] == `FBMC_GRP_YNEC);
  wire isTcmiy = (instr[7:4] == `FBMC_GRP_TCMIY);
  wire isBitOp = (instr[7:4] == `FBMC_GRP_BIT);
  wire isSbit  = isBitOp & (instr[3:2] == 2'b00);
  wire isRbit  = isBitOp & (instr[3:2] == 2'b01);
  wire isTbit  = isBitOp & (instr[3:2] == 2'b10);
  wire isLdx   = isBitOp & (instr[3:2] == 2'b11);
  wire isComx  = (instr == `FBMC_OP_COMX);
  wire isTdo   = (instr == `FBMC_OP_TDO);
  wire isClo   = (instr == `FBMC_OP_CLO);
  wire isRstr  = (instr == `FBMC_OP_RSTR);
  wire isSetr  = (instr == `FBMC_OP_SETR);
  wire isRetn  = (instr == `FBMC_OP_RETN);
  wire isFixed = isBr | isCall | isLdp | isTcy | isYnec | isTcmiy | isBitOp |
                 isComx | isTdo | isClo | isRstr | isSetr | isRetn;

  // ----------------------------------------------------------------
  // Instruction decode array
  // ----------------------------------------------------------------
  reg  [15:0] microOps;
  reg  [15:0] need;
  integer     t;

  always @* begin
    microOps = 16'h0000;
    need     = 16'h0000;
    for (t = 0; t < `FBMC_IPLA_TERMS; t = t + 1) begin
      need = instrArray[t][15:0];
      if (need != 16'h0000 && (need[7:0] & ~instr) == 8'h00 &&
          (need[15:8] & instr) == 8'h00) begin
        microOps = microOps | instrArray[t][31:16];  // [R24]
      end
    end
    if (isFixed) begin
      microOps = 16'h0000;
    end
  end

  wire moCkp  = microOps[`FBMC_MO_CKP-16];
  wire moYtp  = microOps[`FBMC_MO_YTP-16];
  wire moMtp  = microOps[`FBMC_MO_MTP-16];
  wire moAtn  = microOps[`FBMC_MO_ATN-16];
  wire moNatn = microOps[`FBMC_MO_NATN-16];
  wire moMtn  = microOps[`FBMC_MO_MTN-16];
  wire moFtn  = microOps[`FBMC_MO_FTN-16];
  wire moCkn  = microOps[`FBMC_MO_CKN-16];
  wire moNe   = microOps[`FBMC_MO_NE-16];
  wire moC8   = microOps[`FBMC_MO_C8-16];
  wire moCin  = microOps[`FBMC_MO_CIN-16];
  wire moSto  = microOps[`FBMC_MO_STO-16];
  wire moCkm  = microOps[`FBMC_MO_CKM-16];
  wire moAuta = microOps[`FBMC_MO_AUTA-16];
  wire moAuty = microOps[`FBMC_MO_AUTY-16];
  wire moStsl = microOps[`FBMC_MO_STSL-16];

  // ----------------------------------------------------------------
  // Adder and status logic
  // ----------------------------------------------------------------
  wire [3:0] ckBus = (instr[7:6] == 2'b01) ? konst : kIn;  // [R20]
  wire [3:0] pOp = ({4{moCkp}} & ckBus) | ({4{moYtp}} & wordPtr) |
                   ({4{moMtp}} & memWord);  // [R14]
  wire [3:0] nOp = ({4{moAtn}} & acc) | ({4{moNatn}} & ~acc) |
                   ({4{moMtn}} & memWord) | ({4{moFtn}} & 4'hf) |
                   ({4{moCkn}} & ckBus);  // [R14] [R15]
  wire [4:0] sum = {1'b0, pOp} + {1'b0, nOp} + {4'h0, moCin};
  wire       carryOk = ~moC8 | sum[4];  // [R17]
  wire       diffOk  = ~moNe | (pOp != nOp);  // [R18]
  wire       aluStat = carryOk & diffOk;

  reg next_status;

  always @* begin
    next_status = 1'b1;  // [R17]
    if (isYnec) begin
      next_status = (wordPtr != konst);  // [R04] [R18]
    end else if (isTbit) begin
      next_status = memWord[bitSel];  // [R07]
    end else if (!isFixed) begin
      next_status = aluStat;  // [R16] [R20]
    end
  end

  // ----------------------------------------------------------------
  // Program counter step
  // ----------------------------------------------------------------
  wire       pcFb   = (pc[5] ~^ pc[4]) ^ (pc[4:0] == 5'h1f);
  wire [5:0] pcNext = {pc[4:0], pcFb};  // [R09]
  wire       taken  = status & (isBr | isCall);  // [R19]

  // ----------------------------------------------------------------
  // Sequencer and registers
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (rst) begin
      phase            <= 3'h0;
      page             <= `FBMC_START_PAGE;  // [R09]
      pageBuf          <= `FBMC_START_PAGE;
      pc               <= `FBMC_START_PC;
      retAddr          <= 6'h00;
      callMode         <= 1'b0;
      fileSel          <= 2'h0;
      wordPtr          <= 4'h0;
      acc              <= 4'h0;
      status           <= 1'b1;  // [R27]
      status_latch_bit <= 1'b0;
      outLatch         <= 5'h00;  // [R27]
      strobeOut        <= {`FBMC_R_COUNT{1'b0}};  // [R27]
    end else if (run) begin
      if (step) begin
        phase  <= 3'h0;
        status <= next_status;
        pc     <= pcNext;
        if (taken) begin
          pc <= instr[5:0];  // [R10]
          if (isCall && !callMode) begin
            retAddr  <= pcNext;  // [R11]
            callMode <= 1'b1;
            page     <= pageBuf;  // [R12]
            pageBuf  <= page;  // [R13]
          end else if (!callMode) begin
            page <= pageBuf;  // [R12]
          end
        end
        if (isRetn && callMode) begin
          pc       <= retAddr;  // [R11]
          page     <= pageBuf;
          callMode <= 1'b0;
        end
        if (isLdp && !callMode) begin
          pageBuf <= konst;  // [R12] [R13]
        end
        if (isLdx) begin
          fileSel <= instr[1:0];  // [R03]
        end
        if (isComx) begin
          fileSel <= ~fileSel;  // [R03]
        end
        if (isTcy) begin
          wordPtr <= konst;  // [R04]
        end
        if (isTcmiy) begin
          wordPtr <= wordPtr + 4'h1;  // [R04]
        end
        if (moAuty) begin
          wordPtr <= sum[3:0];  // [R04] [R06] [R16]
        end
        if (moAuta) begin
          acc <= sum[3:0];  // [R06] [R16] [R20]
        end
        if (moStsl) begin
          status_latch_bit <= aluStat;  // [R22]
        end
        if (isTdo) begin
          outLatch <= {status_latch_bit, acc};  // [R22]
        end
        if (isClo) begin
          outLatch <= 5'h00;
        end
        if ((isSetr || isRstr) && wordPtr < `FBMC_R_COUNT) begin
          strobeOut[wordPtr] <= isSetr;  // [R21]
        end
      end else begin
        phase <= phase + 3'h1;  // [R26]
      end
    end
  end

  // ----------------------------------------------------------------
  // Data memory writes
  // ----------------------------------------------------------------
  wire [3:0] bitMask = 4'h1 << bitSel;

  reg        memWrite;
  reg  [3:0] next_memWord;

  always @* begin
    memWrite     = 1'b1;
    next_memWord = memWord;
    if (isTcmiy || moCkm) begin
      next_memWord = isTcmiy ? konst : ckBus;  // [R05]
    end else if (moSto) begin
      next_memWord = acc;  // [R05]
    end else if (isSbit) begin
      next_memWord = memWord | bitMask;  // [R07]
    end else if (isRbit) begin
      next_memWord = memWord & ~bitMask;  // [R07]
    end else begin
      memWrite = 1'b0;
    end
  end

  always @(posedge clock) begin
    if (step && memWrite && !rst) begin
      dataMem[ramAddr] <= next_memWord;
    end
  end

  // ----------------------------------------------------------------
  // Output decode array
  // ----------------------------------------------------------------
  reg  [7:0] next_decodedOut;
  reg  [9:0] oNeed;
  integer    u;

  always @* begin
    next_decodedOut = 8'h00;
    oNeed           = 10'h000;
    for (u = 0; u < `FBMC_OPLA_TERMS; u = u + 1) begin
      oNeed = outArray[u][9:0];
      if (oNeed != 10'h000 && (oNeed[4:0] & ~outLatch) == 5'h00 &&
          (oNeed[9:5] & outLatch) == 5'h00) begin
        next_decodedOut = next_decodedOut | outArray[u][17:10];  // [R23]
      end
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      decodedOut <= 8'h00;
    end else begin
      decodedOut <= next_decodedOut;  // [R23]
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  wire inRom  = (regAddr < `FBMC_IPLA_BASE);
  wire inIpla = (regAddr >= `FBMC_IPLA_BASE) &&
                (regAddr < `FBMC_IPLA_BASE + `FBMC_IPLA_TERMS);
  wire inOpla = (regAddr >= `FBMC_OPLA_BASE) &&
                (regAddr < `FBMC_OPLA_BASE + `FBMC_OPLA_TERMS);
  wire [10:0] iIdx = regAddr - `FBMC_IPLA_BASE;
  wire [10:0] oIdx = regAddr - `FBMC_OPLA_BASE;
  wire [31:0] stateWord = {outLatch, status_latch_bit, status, acc, wordPtr,
                           fileSel, callMode, pageBuf, page, pc};

  always @(posedge clock) begin
    if (regWrite) begin
      if (inRom) begin
        progMem[regAddr[9:0]] <= regWrData[7:0];
      end
      if (inIpla) begin
        instrArray[iIdx[4:0]] <= regWrData;
      end
      if (inOpla) begin
        outArray[oIdx[4:0]] <= regWrData[17:0];
      end
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      run <= `FBMC_RUN_RESET;
    end else if (regWrite && regAddr == `FBMC_CTRL_ADDR) begin
      run <= regWrData[`FBMC_CTRL_RUN];
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      regRdData <= 32'h00000000;
    end else if (regRead) begin
      if (inRom) begin
        regRdData <= {24'h000000, progMem[regAddr[9:0]]};
      end else if (inIpla) begin
        regRdData <= instrArray[iIdx[4:0]];
      end else if (inOpla) begin
        regRdData <= {14'h0000, outArray[oIdx[4:0]]};
      end else if (regAddr == `FBMC_CTRL_ADDR) begin
        regRdData <= {31'h00000000, run};
      end else if (regAddr == `FBMC_STATE_ADDR) begin
        regRdData <= stateWord;
      end else begin
        regRdData <= 32'h00000000;
      end
    end else begin
      regRdData <= 32'h00000000;
    end
  end

endmodule // fbmc_core

/* File: pkg/fbmc_defines.vh */
// Constants for the four-bit microcomputer core
`ifndef FBMC_DEFINES_VH
`define FBMC_DEFINES_VH
// ------------------------------------------------------------------
// Sizes and timing
// ------------------------------------------------------------------
`define FBMC_OSC_PER_CYCLE  3'h6
`define FBMC_ROM_WORDS      1024
`define FBMC_RAM_WORDS      64
`define FBMC_R_COUNT        11
`define FBMC_IPLA_TERMS     30
`define FBMC_OPLA_TERMS     20
// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define FBMC_START_PAGE     4'hf
`define FBMC_START_PC       6'h00
`define FBMC_RUN_RESET      1'b0
// ------------------------------------------------------------------
// Register port map (word addresses)
// ------------------------------------------------------------------
`define FBMC_ROM_BASE       11'h000
`define FBMC_IPLA_BASE      11'h400
`define FBMC_OPLA_BASE      11'h440
`define FBMC_CTRL_ADDR      11'h480
`define FBMC_STATE_ADDR     11'h481
`define FBMC_CTRL_RUN       0
// ------------------------------------------------------------------
// Micro-operation bit positions in an instruction decode term
// ------------------------------------------------------------------
`define FBMC_MO_CKP   16
`define FBMC_MO_YTP   17
`define FBMC_MO_MTP   18
`define FBMC_MO_ATN   19
`define FBMC_MO_NATN  20
`define FBMC_MO_MTN   21
`define FBMC_MO_FTN   22
`define FBMC_MO_CKN   23
`define FBMC_MO_NE    24
`define FBMC_MO_C8    25
`define FBMC_MO_CIN   26
`define FBMC_MO_STO   27
`define FBMC_MO_CKM   28
`define FBMC_MO_AUTA  29
`define FBMC_MO_AUTY  30
`define FBMC_MO_STSL  31
// ------------------------------------------------------------------
// Fixed opcodes
// ------------------------------------------------------------------
`define FBMC_OP_COMX  8'h00
`define FBMC_OP_TDO   8'h0a
`define FBMC_OP_CLO   8'h0b
`define FBMC_OP_RSTR  8'h0c
`define FBMC_OP_SETR  8'h0d
`define FBMC_OP_RETN  8'h0f
`define FBMC_GRP_LDP  4'h1
`define FBMC_GRP_TCY  4'h4
`define FBMC_GRP_YNEC 4'h5
`define FBMC_GRP_TCMIY 4'h6
`define FBMC_GRP_BIT  4'h3
`endif

/* File: sim/fbmc_core_properties.sv */
// Port checker for the four-bit microcomputer core
`timescale 1ns/10ps
`include "fbmc_defines.vh"

module fbmc_core_properties (
  // Clock and reset
  input wire        clock,
  input wire        rst,
  // Register port
  input wire [10:0] regAddr,
  input wire [31:0] regWrData,
  input wire        regWrite,
  input wire        regRead,
  input wire [31:0] regRdData,
  // Outputs
  input wire [10:0] strobeOut,
  input wire [7:0]  decodedOut
);
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence wrCtrl;
    regWrite && regAddr == `FBMC_CTRL_ADDR;
  endsequence
  sequence rdCtrl;
    regRead && regAddr == `FBMC_CTRL_ADDR;
  endsequence
  sequence rdStateAfterRst;
    $fell(rst) ##1 (regRead && regAddr == `FBMC_STATE_ADDR);
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_RST_CLEAR: assert property ($fell(rst) |-> strobeOut == 11'h0 && decodedOut == 8'h0)
    else $error("outputs not cleared by reset");
  AST_RST_STATE: assert property (rdStateAfterRst |=> regRdData[25]
    && regRdData[13:0] == {4'hf, 4'hf, 6'h00})
    else $error("start state wrong after reset");
  AST_RD_IDLE: assert property (!regRead |=> regRdData == 32'h0)
    else $error("read data outside read answer");
  AST_UNMAPPED: assert property (regRead && regAddr == 11'h7ff |=> regRdData == 32'h0)
    else $error("unmapped read not zero");
  AST_CTRL_RB: assert property (wrCtrl ##2 rdCtrl |=> regRdData[0] == $past(regWrData[0], 3))
    else $error("run bit readback wrong");
  AST_STROBE_ONEBIT: assert property (!$past(rst) |-> $onehot0(strobeOut ^ $past(strobeOut)))
    else $error("more than one strobe changed");
  AST_STROBE_SPACE: assert property ($changed(strobeOut) && !$past(rst)
    |=> $stable(strobeOut)[*5])
    else $error("strobes changed within one instruction");
  AST_DEC_SPACE: assert property ($changed(decodedOut) && !$past(rst)
    |=> $stable(decodedOut)[*5])
    else $error("outputs changed within one instruction");
endmodule // fbmc_core_properties

/* File: sim/fbmc_key_source.sv */
// Fixed-rate data source on the four data inputs
`timescale 1ns/10ps

module fbmc_key_source #(
  parameter logic [3:0] WORD   = 4'h9,
  parameter int         HS_BIT = 0
) (
  // Clock and reset
  input  wire        clock,
  input  wire        rst,
  // Strobes from the core
  input  wire [10:0] strobeOut,
  // Data word to the core
  output logic       keyWeight1,
  output logic       keyWeight2,
  output logic       keyWeight4,
  output logic       keyWeight8
);
  logic [3:0] word = 4'h0;

  // Lines are pulled low until the handshake strobe is raised
  always @(posedge clock) begin
    if (rst || !strobeOut[HS_BIT]) begin
      word <= 4'h0;
    end else begin
      word <= WORD;
    end
  end
  assign {keyWeight8, keyWeight4, keyWeight2, keyWeight1} = word;
endmodule // fbmc_key_source

/* File: sim/fbmc_core_tb_top.sv */
// Self-checking testbench for the four-bit microcomputer core
`timescale 1ns/10ps
`include "fbmc_defines.vh"

module fbmc_core_tb_top;
  logic        clock;
  logic        rst;
  logic [10:0] regAddr;
  logic [31:0] regWrData;
  logic        regWrite;
  logic        regRead;
  wire  [31:0] regRdData;
  wire         kw1;
  wire         kw2;
  wire         kw4;
  wire         kw8;
  wire  [10:0] strobeOut;
  wire  [7:0]  decodedOut;
  int          miscompares;
  int          totalChecks;
  localparam logic [26:0] RST_STATE = {2'b01, 4'h0, 4'h0, 2'h0, 1'b0, 4'hf, 4'hf, 6'h00};
  localparam logic [26:0] END_STATE = {2'b01, 4'h9, 4'ha, 2'h1, 1'b0, 4'h3, 4'h3, 6'h03};
  localparam logic [31:0] RAM_STATE = {5'h13, 2'b11, 4'h3, 4'h5, 2'h0, 1'b0, 4'hf, 4'hf, 6'h18};
  localparam logic [31:0] CLO_STATE = {5'h00, 2'b11, 4'h3, 4'h5, 2'h0, 1'b0, 4'hf, 4'hf, 6'h30};

  fbmc_core dut (.clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .input_bit_weight1(kw1), .input_bit_weight2(kw2), .input_bit_weight4(kw4),
    .input_bit_weight8(kw8), .strobeOut(strobeOut), .decodedOut(decodedOut));
  fbmc_key_source peer (.clock(clock), .rst(rst), .strobeOut(strobeOut),
    .keyWeight1(kw1), .keyWeight2(kw2), .keyWeight4(kw4), .keyWeight8(kw8));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [5:0] nxtPc(input logic [5:0] p);
    nxtPc = {p[4:0], ~(p[5] ^ p[4]) ^ (p[4:0] == 5'h1f)};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    totalChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [10:0] a, input logic [31:0] d);
    @(posedge clock);
    regWrite <= 1'b1; regAddr <= a; regWrData <= d;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [10:0] a, output logic [31:0] d);
    @(posedge clock);
    regRead <= 1'b1; regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask
  task endSim;
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic waitPc(input logic [9:0] at, output logic [31:0] d);
    int i;
    d = 32'h0;
    for (i = 0; i < 200 && d[9:0] !== at; i++) rd(`FBMC_STATE_ADDR, d);
    if (i == 200) begin
      miscompares++;
      $display("BAD %0t program hang", $time);
      endSim;
    end
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  task automatic testReset(input int cyc);
    logic [31:0] d;
    @(posedge clock);
    rst <= 1'b1;
    repeat (cyc) @(posedge clock);
    rst <= 1'b0;
    rd(`FBMC_STATE_ADDR, d);
    chk({5'h0, d[26:0]}, {5'h0, RST_STATE}, "reset state");
    chk({21'h0, strobeOut}, 32'h0, "strobes");
    chk({24'h0, decodedOut}, 32'h0, "outputs");
    rd(`FBMC_CTRL_ADDR, d);
    chk(d, 32'h0, "run bit");
    rd(11'h7ff, d);
    chk(d, 32'h0, "unmapped");
    $display("test reset done");
  endtask

  task automatic testProgram;
    logic [31:0] d;
    logic [5:0]  p;
    int          i;
    logic [7:0]  prog [14] = '{8'h40, 8'h0d, 8'h08, 8'h0a, 8'h4b, 8'h0d, 8'h4a,
                               8'h0d, 8'h5a, 8'hbf, 8'h3e, 8'h00, 8'h13, 8'h80};
    for (i = 0; i < 30; i++) wr(`FBMC_IPLA_BASE + 11'(i), 32'h0);
    for (i = 0; i < 20; i++) wr(`FBMC_OPLA_BASE + 11'(i), 32'h0);
    // Opcode 08 moves the input word to the accumulator
    wr(`FBMC_IPLA_BASE, 32'h2080f708);
    // Latch value 09 drives a5
    wr(`FBMC_OPLA_BASE, 32'h000296c9);
    p = 6'h00;
    for (i = 0; i < 14; i++) begin
      wr({1'b0, 4'hf, p}, {24'h0, prog[i]});
      p = nxtPc(p);
    end
    wr({1'b0, 4'h3, 6'h00}, 32'h15);
    wr({1'b0, 4'h3, 6'h01}, 32'hc0);
    wr({1'b0, 4'h3, 6'h03}, 32'h83);
    wr({1'b0, 4'h5, 6'h00}, 32'h0f);
    wr(`FBMC_CTRL_ADDR, 32'h1);
    rd(`FBMC_CTRL_ADDR, d);
    chk(d, 32'h1, "run bit");
    waitPc({4'h3, 6'h03}, d);
    chk({5'h0, d[26:0]}, {5'h0, END_STATE}, "end state");
    chk({21'h0, strobeOut}, 32'h401, "strobes");
    chk({24'h0, decodedOut}, 32'ha5, "outputs");
    $display("test program done");
  endtask

  task automatic testRam;
    logic [31:0] d;
    logic [5:0]  p;
    int          i;
    logic [7:0]  prog [26] = '{8'h41, 8'h0d, 8'h42, 8'h0d, 8'h41, 8'h0c, 8'h45, 8'h63,
                               8'h6c, 8'h45, 8'h04, 8'h46, 8'h02, 8'h45, 8'h02, 8'hbf,
                               8'h03, 8'h30, 8'h37, 8'h3a, 8'hbf, 8'h04, 8'h05, 8'h0a,
                               8'h98, 8'hb0};
    // Subtract, store, load and compare opcodes through the decode array
    wr(`FBMC_IPLA_BASE + 11'h1, 32'h2614fd02);
    wr(`FBMC_IPLA_BASE + 11'h2, 32'h0800fc03);
    wr(`FBMC_IPLA_BASE + 11'h3, 32'h2020fb04);
    wr(`FBMC_IPLA_BASE + 11'h4, 32'h810afa05);
    // Latch value 13 drives 3c
    wr(`FBMC_OPLA_BASE + 11'h1, 32'h0000f193);
    p = 6'h00;
    for (i = 0; i < 26; i++) begin
      wr({1'b0, 4'hf, p}, {24'h0, prog[i]});
      p = nxtPc(p);
    end
    wr(`FBMC_CTRL_ADDR, 32'h1);
    waitPc({4'hf, 6'h18}, d);
    chk(d, RAM_STATE, "ram state");
    chk({21'h0, strobeOut}, 32'h004, "ram strobes");
    chk({24'h0, decodedOut}, 32'h3c, "ram outputs");
    wr({1'b0, 4'hf, 6'h18}, 32'h0b);
    waitPc({4'hf, 6'h30}, d);
    chk(d, CLO_STATE, "cleared state");
    chk({24'h0, decodedOut}, 32'h00, "cleared outputs");
    $display("test ram done");
  endtask

  initial begin
    rst = 1'b1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 11'h0;
    regWrData = 32'h0;
    miscompares = 0;
    totalChecks = 0;
    testReset(4);
    testProgram;
    testReset(2);
    testRam;
    endSim;
  end
endmodule // fbmc_core_tb_top

bind fbmc_core fbmc_core_properties u_props (.clock(clock), .rst(rst), .regAddr(regAddr),
  .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .strobeOut(strobeOut), .decodedOut(decodedOut));
